/* File: inc/phc_cfg.svh */
// register offsets, field positions and reset values of the pump command handler
// assumes a 32-bit APB slave with word-aligned registers
`ifndef PHC_CFG_SVH
`define PHC_CFG_SVH

`define PHC_OFF_CTRL 12'h000
`define PHC_OFF_STAT 12'h004
`define PHC_OFF_ISTAT 12'h008
`define PHC_OFF_IMASK 12'h00C
`define PHC_OFF_LAST 12'h010

`define PHC_CTRL_MUTE 0
`define PHC_INT_ANS 0
`define PHC_INT_MODE 1
`define PHC_INT_ALARM 2
`define PHC_INT_PUMP 3
`define PHC_INT_W 4

`define PHC_CTRL_RST 1'h0
`define PHC_IMASK_RST 4'h0

`endif

/* File: inc/phc_pkg.sv */
// types of the pump command handler: modes, pump states, codes and carriers
// assumes nothing beyond a SystemVerilog compiler
package phc_pkg;

    typedef enum logic [3:0] {
        MODE_LOCAL = 4'h1,
        MODE_REMOTE = 4'h2,
        MODE_SER232 = 4'h4,
        MODE_SER485 = 4'h8
    } phc_mode_type;

    typedef enum logic [2:0] {
        PUMP_STOP = 3'h1,
        PUMP_ACCEL = 3'h2,
        PUMP_DECEL = 3'h4
    } phc_pump_type;

    typedef enum logic [0:0] {
        PORT_232 = 1'h0,
        PORT_485 = 1'h1
    } phc_port_type;

    typedef enum logic [3:0] {
        mode_query_cmd = 4'h0,
        online_request_cmd = 4'h1,
        offline_request_cmd = 4'h2,
        start_cmd = 4'h3,
        stop_cmd = 4'h4,
        reset_cmd = 4'h5
    } phc_cmd_code_type;

    typedef enum logic [3:0] {
        mode_local_ans = 4'h0,
        mode_remote_ans = 4'h1,
        mode_serial232_ans = 4'h2,
        mode_serial485_ans = 4'h3,
        accel_started_ans = 4'h4,
        decel_started_ans = 4'h5,
        buzzer_off_ans = 4'h6,
        failure_cleared_ans = 4'h7,
        failure_persists_ans = 4'h8,
        operation_invalid_ans = 4'h9
    } phc_ans_code_type;

    typedef struct packed {
        logic valid;
        phc_port_type port;
        phc_cmd_code_type code;
    } phc_cmd_type;

    typedef struct packed {
        logic valid;
        phc_port_type port;
        phc_ans_code_type code;
        logic [15:0] sub;
    } phc_ans_type;

endpackage : phc_pkg

/* File: rtl/phc_top.sv */
// pump command handler: mode and operation commands from two serial ports
// assumes framing is done outside; commands arrive decoded, one cycle each
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phc_cfg.svh"

module phc_top #(
    parameter int CODE_W = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    // decoded commands and answers
    input wire phc_pkg::phc_cmd_type cmd_in,
    output phc_pkg::phc_ans_type ans_out,
    // front panel
    input wire logic local_sel_in,
    input wire logic start_key_in,
    input wire logic stop_key_in,
    input wire logic reset_key_in,
    // pump and fault status
    input wire logic pump_halted_in,
    input wire logic fault_active_in,
    input wire logic [CODE_W-1:0] fault_code_in,
    // outputs to the drive and panel
    output phc_pkg::phc_mode_type mode_out,
    output phc_pkg::phc_pump_type pump_out,
    output logic buzzer_out,
    output logic alarm_out
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // the alarm code is two characters of eight bits
    if (CODE_W != 16) begin : g_bad_code_w
        $error("phc_top: CODE_W must be 16");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phc_pkg::phc_mode_type mode_reg;
    phc_pkg::phc_mode_type mode_next;
    phc_pkg::phc_pump_type pump_reg;
    logic alarm_reg;
    logic buzz_reg;
    logic sel_prev_reg;
    logic mute_reg;
    logic [`PHC_INT_W-1:0] istat_reg;
    logic [`PHC_INT_W-1:0] imask_reg;
    phc_pkg::phc_ans_type ans_reg;
    phc_pkg::phc_ans_type ans_next;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;

    logic sel_change;
    logic do_start;
    logic do_stop;
    logic do_buzz_off;
    logic do_clear;
    logic port_ok;
    logic alarm_rise;
    logic [`PHC_INT_W-1:0] ev;

    function automatic phc_pkg::phc_ans_code_type mode_ans(
        input phc_pkg::phc_mode_type m
    );
        case (m)
            phc_pkg::MODE_LOCAL: mode_ans = phc_pkg::mode_local_ans;
            phc_pkg::MODE_REMOTE: mode_ans = phc_pkg::mode_remote_ans;
            phc_pkg::MODE_SER232: mode_ans = phc_pkg::mode_serial232_ans;
            default: mode_ans = phc_pkg::mode_serial485_ans;
        endcase
    endfunction : mode_ans

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    assign sel_change = local_sel_in != sel_prev_reg;

    always_comb begin
        mode_next = mode_reg;
        do_start = 1'b0;
        do_stop = 1'b0;
        do_buzz_off = 1'b0;
        do_clear = 1'b0;
        ans_next = '0;
        ans_next.port = cmd_in.port;
        ans_next.valid = cmd_in.valid;
        ans_next.code = phc_pkg::operation_invalid_ans;
        port_ok = (mode_reg == phc_pkg::MODE_SER232 && cmd_in.port == phc_pkg::PORT_232)
            || (mode_reg == phc_pkg::MODE_SER485 && cmd_in.port == phc_pkg::PORT_485);
        if (sel_change) begin
            // the selector wins over a serial request in the same cycle
            mode_next = local_sel_in ? phc_pkg::MODE_LOCAL : phc_pkg::MODE_REMOTE;
        end else if (cmd_in.valid) begin
            case (cmd_in.code)
                phc_pkg::online_request_cmd: begin
                    if (mode_reg == phc_pkg::MODE_REMOTE) begin
                        mode_next = (cmd_in.port == phc_pkg::PORT_232) ?
                            phc_pkg::MODE_SER232 : phc_pkg::MODE_SER485;
                    end
                end
                phc_pkg::offline_request_cmd: begin
                    if (mode_reg == phc_pkg::MODE_SER232 || mode_reg == phc_pkg::MODE_SER485) begin
                        mode_next = phc_pkg::MODE_REMOTE;
                    end
                end
                default: begin
                end
            endcase
        end
        if (cmd_in.valid) begin
            case (cmd_in.code)
                phc_pkg::mode_query_cmd,
                phc_pkg::online_request_cmd,
                phc_pkg::offline_request_cmd: begin
                    ans_next.code = mode_ans(mode_next);
                end
                phc_pkg::start_cmd: begin
                    if (port_ok && pump_reg != phc_pkg::PUMP_ACCEL && !alarm_reg) begin
                        do_start = 1'b1;
                        ans_next.code = phc_pkg::accel_started_ans;
                    end
                end
                phc_pkg::stop_cmd: begin
                    if (port_ok && pump_reg == phc_pkg::PUMP_ACCEL) begin
                        do_stop = 1'b1;
                        ans_next.code = phc_pkg::decel_started_ans;
                    end
                end
                phc_pkg::reset_cmd: begin
                    if (port_ok && alarm_reg) begin
                        if (buzz_reg) begin
                            do_buzz_off = 1'b1;
                            ans_next.code = phc_pkg::buzzer_off_ans;
                        end else begin
                            do_clear = 1'b1;
                            if (fault_active_in) begin
                                ans_next.code = phc_pkg::failure_persists_ans;
                                ans_next.sub = fault_code_in;
                            end else begin
                                ans_next.code = phc_pkg::failure_cleared_ans;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end else begin
            // panel keys act only when no serial command is taken
            do_start = start_key_in && pump_reg != phc_pkg::PUMP_ACCEL && !alarm_reg;
            do_stop = stop_key_in && pump_reg == phc_pkg::PUMP_ACCEL;
            do_buzz_off = reset_key_in && alarm_reg && buzz_reg;
            do_clear = reset_key_in && alarm_reg && !buzz_reg;
        end
    end

    // ----------------------------------------------------------------
    // operation mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode_reg <= phc_pkg::MODE_REMOTE;
            sel_prev_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            sel_prev_reg <= local_sel_in;
        end
    end

    // ----------------------------------------------------------------
    // pump run state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pump_reg <= phc_pkg::PUMP_STOP;
        end else begin
            case (pump_reg)
                phc_pkg::PUMP_STOP: begin
                    if (do_start) begin
                        pump_reg <= phc_pkg::PUMP_ACCEL;
                    end
                end
                phc_pkg::PUMP_ACCEL: begin
                    // a new alarm brakes the pump as a stop would
                    if (do_stop || alarm_rise) begin
                        pump_reg <= phc_pkg::PUMP_DECEL;
                    end
                end
                phc_pkg::PUMP_DECEL: begin
                    if (do_start) begin
                        pump_reg <= phc_pkg::PUMP_ACCEL;
                    end else if (pump_halted_in) begin
                        pump_reg <= phc_pkg::PUMP_STOP;
                    end
                end
                default: begin
                    pump_reg <= phc_pkg::PUMP_STOP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // alarm latch and buzzer
    // ----------------------------------------------------------------
    assign alarm_rise = fault_active_in && !alarm_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            alarm_reg <= 1'b0;
            buzz_reg <= 1'b0;
        end else if (do_clear) begin
            // a fault still present re-latches and sounds again
            alarm_reg <= fault_active_in;
            buzz_reg <= fault_active_in;
        end else if (alarm_rise) begin
            alarm_reg <= 1'b1;
            buzz_reg <= 1'b1;
        end else if (do_buzz_off) begin
            buzz_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ans_reg <= '0;
        end else begin
            ans_reg <= ans_next;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    logic wr_fire;
    assign wr_fire = psel_in && penable_in && pready_reg && pwrite_in;

    always_comb begin
        ev = '0;
        ev[`PHC_INT_ANS] = ans_next.valid;
        ev[`PHC_INT_MODE] = mode_next != mode_reg;
        ev[`PHC_INT_ALARM] = alarm_rise;
        ev[`PHC_INT_PUMP] = do_start || do_stop;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            istat_reg <= '0;
            imask_reg <= `PHC_IMASK_RST;
            mute_reg <= `PHC_CTRL_RST;
        end else begin
            // a new event wins over a clear in the same cycle
            if (wr_fire && paddr_in == `PHC_OFF_ISTAT) begin
                istat_reg <= (istat_reg & ~pwdata_in[`PHC_INT_W-1:0]) | ev;
            end else begin
                istat_reg <= istat_reg | ev;
            end
            if (wr_fire && paddr_in == `PHC_OFF_IMASK) begin
                imask_reg <= pwdata_in[`PHC_INT_W-1:0];
            end
            if (wr_fire && paddr_in == `PHC_OFF_CTRL) begin
                mute_reg <= pwdata_in[`PHC_CTRL_MUTE];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |((istat_reg | ev) & imask_reg);
        end
    end

    // ----------------------------------------------------------------
    // apb slave: no wait state, read data sampled in setup
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (psel_in && !penable_in && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
            case (paddr_in)
                `PHC_OFF_CTRL: prdata_reg[`PHC_CTRL_MUTE] <= mute_reg;
                `PHC_OFF_STAT: prdata_reg[9:0] <= {alarm_reg, buzz_reg, 1'b0, pump_reg, mode_reg};
                `PHC_OFF_ISTAT: prdata_reg[`PHC_INT_W-1:0] <= istat_reg;
                `PHC_OFF_IMASK: prdata_reg[`PHC_INT_W-1:0] <= imask_reg;
                `PHC_OFF_LAST: prdata_reg[20:0] <= {ans_reg.port, ans_reg.code, ans_reg.sub};
                default: pslverr_reg <= 1'b1;
            endcase
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign irq_out = irq_reg;
    assign ans_out = ans_reg;
    assign mode_out = mode_reg;
    assign pump_out = pump_reg;
    // mute only gates the pin; the buzzer state still drives reset answers
    assign buzzer_out = buzz_reg && !mute_reg;
    assign alarm_out = alarm_reg;

endmodule : phc_top
`default_nettype wire

/* File: tb/phc_props.sv */
// assertions on the ports of the pump command handler
// assumes it is bound to phc_top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module phc_props #(
    parameter int CODE_W = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // watched ports
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire phc_pkg::phc_cmd_type cmd_in,
    input wire phc_pkg::phc_ans_type ans_out,
    input wire logic local_sel_in,
    input wire logic fault_active_in,
    input wire logic [CODE_W-1:0] fault_code_in,
    input wire phc_pkg::phc_mode_type mode_out,
    input wire phc_pkg::phc_pump_type pump_out,
    input wire logic buzzer_out,
    input wire logic alarm_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic port_ok;
    logic is_op;
    assign port_ok = (cmd_in.port == phc_pkg::PORT_232) ? (mode_out == phc_pkg::MODE_SER232)
                                                       : (mode_out == phc_pkg::MODE_SER485);
    assign is_op = cmd_in.valid && cmd_in.code inside {phc_pkg::start_cmd, phc_pkg::stop_cmd,
                                                       phc_pkg::reset_cmd};
    function automatic phc_pkg::phc_ans_code_type mode_ans(input phc_pkg::phc_mode_type m);
        case (m)
            phc_pkg::MODE_LOCAL: return phc_pkg::mode_local_ans;
            phc_pkg::MODE_REMOTE: return phc_pkg::mode_remote_ans;
            phc_pkg::MODE_SER232: return phc_pkg::mode_serial232_ans;
            default: return phc_pkg::mode_serial485_ans;
        endcase
    endfunction : mode_ans
    sequence s_cmd(phc_pkg::phc_cmd_code_type c);
        cmd_in.valid && cmd_in.code == c;
    endsequence
    // a reset the handler acts on: right port, alarm latched
    sequence s_rst;
        s_cmd(phc_pkg::reset_cmd) ##0 (port_ok && alarm_out);
    endsequence
    AST_ANS_NEXT:
    assert property (cmd_in.valid |=> ans_out.valid && ans_out.port == $past(cmd_in.port))
        else $error("answer missing or on the wrong port");
    AST_QUERY:
    assert property (s_cmd(phc_pkg::mode_query_cmd) |=> ans_out.code == mode_ans(mode_out))
        else $error("mode query answer wrong");
    AST_ONLINE:
    assert property (s_cmd(phc_pkg::online_request_cmd) ##0 (mode_out == phc_pkg::MODE_REMOTE
        && !local_sel_in && !$past(local_sel_in)) |=> ans_out.code == mode_ans(mode_out)
        && mode_out == (($past(cmd_in.port) == phc_pkg::PORT_232) ? phc_pkg::MODE_SER232
        : phc_pkg::MODE_SER485)) else $error("online request mode wrong");
    AST_OFFLINE:
    assert property (s_cmd(phc_pkg::offline_request_cmd) ##0 (!local_sel_in
        && !$past(local_sel_in) && mode_out inside {phc_pkg::MODE_SER232, phc_pkg::MODE_SER485})
        |=> mode_out == phc_pkg::MODE_REMOTE && ans_out.code == phc_pkg::mode_remote_ans)
        else $error("offline request mode wrong");
    AST_KEEP_LOCAL:
    assert property (cmd_in.valid && mode_out == phc_pkg::MODE_LOCAL && local_sel_in
        && $past(local_sel_in) |=> mode_out == phc_pkg::MODE_LOCAL)
        else $error("local mode left by a command");
    AST_START:
    assert property (s_cmd(phc_pkg::start_cmd) ##0 (port_ok && pump_out != phc_pkg::PUMP_ACCEL
        && !alarm_out && !fault_active_in) |=> ans_out.code == phc_pkg::accel_started_ans
        && pump_out == phc_pkg::PUMP_ACCEL) else $error("start not carried out");
    AST_START_AGAIN:
    assert property (s_cmd(phc_pkg::start_cmd) ##0 (pump_out == phc_pkg::PUMP_ACCEL
        && !fault_active_in) |=> ans_out.code == phc_pkg::operation_invalid_ans
        && pump_out == phc_pkg::PUMP_ACCEL) else $error("repeated start not refused");
    AST_STOP:
    assert property (s_cmd(phc_pkg::stop_cmd) ##0 (port_ok && pump_out == phc_pkg::PUMP_ACCEL)
        |=> ans_out.code == phc_pkg::decel_started_ans && pump_out == phc_pkg::PUMP_DECEL)
        else $error("stop not carried out");
    AST_WRONG_PORT:
    assert property (is_op && !port_ok |=> ans_out.code == phc_pkg::operation_invalid_ans)
        else $error("command from a port not online accepted");
    AST_BUZZ_OFF:
    assert property (s_rst ##0 buzzer_out |=> ans_out.code == phc_pkg::buzzer_off_ans
        && alarm_out && !buzzer_out) else $error("buzzer silence wrong");
    AST_CLEAR:
    assert property (s_rst ##0 (!buzzer_out && !fault_active_in) |=> !alarm_out
        && ans_out.code == phc_pkg::failure_cleared_ans) else $error("alarm clear wrong");
    AST_PERSIST:
    assert property (s_rst ##0 (!buzzer_out && fault_active_in) |=> alarm_out && buzzer_out
        && ans_out.code == phc_pkg::failure_persists_ans && ans_out.sub == $past(fault_code_in))
        else $error("persisting failure answer wrong");
    AST_PREADY:
    assert property (psel_in && !penable_in && !pready_out |=> pready_out)
        else $error("apb access not answered");
endmodule : phc_props
bind phc_top phc_props #(.CODE_W(CODE_W)) props_u (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .pready_out(pready_out), .cmd_in(cmd_in), .ans_out(ans_out), .local_sel_in(local_sel_in),
    .fault_active_in(fault_active_in), .fault_code_in(fault_code_in), .mode_out(mode_out),
    .pump_out(pump_out), .buzzer_out(buzzer_out), .alarm_out(alarm_out)
);
`default_nettype wire

/* File: tb/phc_host_model.sv */
// host computer model: sends one decoded command and awaits its answer
// assumes the handler answers within a few cycles
`timescale 1ns/1ps
`default_nettype none
module phc_host_model (
    // clock
    input wire logic clk_in,
    // command out, answer back
    output phc_pkg::phc_cmd_type cmd_out,
    input wire phc_pkg::phc_ans_type ans_in
);
    initial cmd_out = '0;
    task automatic send(input phc_pkg::phc_port_type p, input phc_pkg::phc_cmd_code_type c,
            output phc_pkg::phc_ans_type a, output logic ok);
        ok = 1'b0;
        a = '0;
        @(posedge clk_in);
        cmd_out <= '{1'b1, p, c};
        // nothing new is sent until the answer is back
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk_in);
            cmd_out <= '0;
            #1;
            if (ans_in.valid === 1'b1) begin
                a = ans_in;
                ok = 1'b1;
            end
        end
    endtask : send
endmodule : phc_host_model
`default_nettype wire

/* File: tb/tb.sv */
// testbench of the pump command handler: apb registers and serial commands
// assumes phc_top, the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "phc_cfg.svh"
module tb;
    localparam phc_pkg::phc_port_type P2 = phc_pkg::PORT_232;
    localparam phc_pkg::phc_port_type P4 = phc_pkg::PORT_485;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, irq_out, buzzer_out, alarm_out;
    logic local_sel_in = 1'b0;
    logic [2:0] key_in = 3'h0;
    logic pump_halted_in = 1'b0;
    logic fault_active_in = 1'b0;
    logic [15:0] fault_code_in = 16'h3431;
    phc_pkg::phc_cmd_type cmd_in;
    phc_pkg::phc_ans_type ans_out;
    phc_pkg::phc_mode_type mode_out;
    phc_pkg::phc_pump_type pump_out;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 clk_in = ~clk_in;
    phc_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .irq_out(irq_out), .cmd_in(cmd_in), .ans_out(ans_out),
        .local_sel_in(local_sel_in), .start_key_in(key_in[0]), .stop_key_in(key_in[1]),
        .reset_key_in(key_in[2]), .pump_halted_in(pump_halted_in),
        .fault_active_in(fault_active_in), .fault_code_in(fault_code_in), .mode_out(mode_out),
        .pump_out(pump_out), .buzzer_out(buzzer_out), .alarm_out(alarm_out));
    phc_host_model host_u (.clk_in(clk_in), .cmd_out(cmd_in), .ans_in(ans_out));
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic lost();
        err_count++;
        $display("Error at %0t: no answer", $time);
        finish_test();
    endtask : lost
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_ans(input phc_pkg::phc_ans_type a, input phc_pkg::phc_port_type p,
            input phc_pkg::phc_ans_code_type c, input logic [15:0] s);
        total_checks++;
        if ({a.valid, a.port, a.code, a.sub} !== {1'b1, p, c, s}) begin
            err_count++;
            $display("Error at %0t: answer %h expected code %h", $time, a, c);
        end
    endtask : chk_ans
    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
            output logic [31:0] rd, output logic er);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= ad;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_in);
            if (pready_out === 1'b1) begin
                rd = prdata_out;
                er = pslverr_out;
                psel_in <= 1'b0;
                penable_in <= 1'b0;
                return;
            end
        end
        lost();
    endtask : apb
    task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, ad, 32'h0, rd, er);
        chk_word(rd, exp);
        chk_word({31'h0, er}, {31'h0, eerr});
    endtask : rd_chk
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, ad, d, rd, er);
    endtask : wr
    task automatic op(input phc_pkg::phc_port_type p, input phc_pkg::phc_cmd_code_type c,
            input phc_pkg::phc_ans_code_type ec, input logic [15:0] es);
        phc_pkg::phc_ans_type a;
        logic ok;
        host_u.send(p, c, a, ok);
        if (!ok) lost();
        chk_ans(a, p, ec, es);
    endtask : op
    task automatic edge_set(input int n);
        repeat (n) @(posedge clk_in);
    endtask : edge_set
    initial begin
        edge_set(3);
        reset_in <= 1'b0;
        rd_chk(`PHC_OFF_STAT, {22'h0, 3'h0, phc_pkg::PUMP_STOP, phc_pkg::MODE_REMOTE}, 1'b0);
        rd_chk(`PHC_OFF_IMASK, 32'h0, 1'b0);
        rd_chk(12'h020, 32'h0, 1'b1);
        wr(`PHC_OFF_CTRL, 32'h1);
        rd_chk(`PHC_OFF_CTRL, 32'h1, 1'b0);
        wr(`PHC_OFF_CTRL, 32'h0);
        op(P2, phc_pkg::mode_query_cmd, phc_pkg::mode_remote_ans, 16'h0);
        op(P2, phc_pkg::offline_request_cmd, phc_pkg::mode_remote_ans, 16'h0);
        op(P2, phc_pkg::start_cmd, phc_pkg::operation_invalid_ans, 16'h0);
        op(P4, phc_pkg::online_request_cmd, phc_pkg::mode_serial485_ans, 16'h0);
        op(P2, phc_pkg::online_request_cmd, phc_pkg::mode_serial485_ans, 16'h0);
        op(P2, phc_pkg::start_cmd, phc_pkg::operation_invalid_ans, 16'h0);
        op(P4, phc_pkg::start_cmd, phc_pkg::accel_started_ans, 16'h0);
        op(P4, phc_pkg::start_cmd, phc_pkg::operation_invalid_ans, 16'h0);
        op(P4, phc_pkg::stop_cmd, phc_pkg::decel_started_ans, 16'h0);
        pump_halted_in <= 1'b1;
        edge_set(1);
        pump_halted_in <= 1'b0;
        op(P4, phc_pkg::reset_cmd, phc_pkg::operation_invalid_ans, 16'h0);
        op(P4, phc_pkg::start_cmd, phc_pkg::accel_started_ans, 16'h0);
        fault_active_in <= 1'b1;
        edge_set(3);
        chk_word({29'h0, alarm_out, buzzer_out, pump_out[2]}, 32'h7);
        op(P2, phc_pkg::reset_cmd, phc_pkg::operation_invalid_ans, 16'h0);
        op(P4, phc_pkg::reset_cmd, phc_pkg::buzzer_off_ans, 16'h0);
        op(P4, phc_pkg::reset_cmd, phc_pkg::failure_persists_ans, 16'h3431);
        chk_word({30'h0, alarm_out, buzzer_out}, 32'h3);
        op(P4, phc_pkg::reset_cmd, phc_pkg::buzzer_off_ans, 16'h0);
        fault_active_in <= 1'b0;
        op(P4, phc_pkg::reset_cmd, phc_pkg::failure_cleared_ans, 16'h0);
        chk_word({30'h0, alarm_out, buzzer_out}, 32'h0);
        op(P4, phc_pkg::offline_request_cmd, phc_pkg::mode_remote_ans, 16'h0);
        local_sel_in <= 1'b1;
        edge_set(3);
        op(P2, phc_pkg::mode_query_cmd, phc_pkg::mode_local_ans, 16'h0);
        op(P2, phc_pkg::online_request_cmd, phc_pkg::mode_local_ans, 16'h0);
        local_sel_in <= 1'b0;
        edge_set(3);
        op(P4, phc_pkg::mode_query_cmd, phc_pkg::mode_remote_ans, 16'h0);
        op(P2, phc_pkg::online_request_cmd, phc_pkg::mode_serial232_ans, 16'h0);
        op(P2, phc_pkg::mode_query_cmd, phc_pkg::mode_serial232_ans, 16'h0);
        rd_chk(`PHC_OFF_LAST, {12'h0, phc_pkg::operation_invalid_ans, 16'h0}, 1'b0);
        rd_chk(`PHC_OFF_ISTAT, 32'hF, 1'b0);
        chk_word({31'h0, irq_out}, 32'h0);
        wr(`PHC_OFF_IMASK, 32'hF);
        edge_set(3);
        chk_word({31'h0, irq_out}, 32'h1);
        wr(`PHC_OFF_ISTAT, 32'hF);
        edge_set(3);
        chk_word({31'h0, irq_out}, 32'h0);
        rd_chk(`PHC_OFF_ISTAT, 32'h0, 1'b0);
        key_in <= 3'h1;
        edge_set(2);
        chk_word({29'h0, pump_out}, 32'h2);
        key_in <= 3'h2;
        edge_set(2);
        chk_word({29'h0, pump_out}, 32'h4);
        finish_test();
    end
endmodule : tb
`default_nettype wire
